// >>> core/mri_cfg.svh
// constants of the multiplexed register input block
`ifndef MRI_CFG_SVH
`define MRI_CFG_SVH
`define MRI_CLK_MHZ 100
`define MRI_DATA_W 16
`define MRI_CH_W 3
`define MRI_NCH 8
`define MRI_DIGIT_W 4
`define MRI_DIGIT_MAX 4'h9
`define MRI_STROBE_US 2000
`define MRI_SETUP_US 180
`define MRI_GAP_US 10
`define MRI_RESPONSE_MS 20
`define MRI_CNT_W 20
`define MRI_REQ_BAD_MASK 16'hfff8
`define MRI_STROBE_IDLE 8'hff
`define MRI_WORD_RST 16'h0000
`endif

// >>> core/mri_pkg.sv
// types shared by the multiplexed register input block
package mri_pkg;
  typedef enum logic [3:0] {
    MRI_IDLE = 4'b0001,
    MRI_SETUP = 4'b0010,
    MRI_HOLD = 4'b0100,
    MRI_GAP = 4'b1000
  } mri_st_e;

  // everything arriving from the field pins and the module switches
  typedef struct packed {
    logic fmt_bcd;
    logic pol_low;
    logic unsettled;
    logic [15:0] data;
  } mri_pins_s;

  typedef struct packed {
    mri_pins_s s1;
    mri_pins_s s2;
    mri_pins_s s3;
    mri_pins_s clean;
  } mri_sync_s;

  typedef struct packed {
    mri_st_e st;
    logic [19:0] cnt;
    logic [2:0] ch;
    logic [2:0] req_ch;
    logic req_valid;
    logic req_err;
    logic [7:0] strobe_n;
    logic [15:0] echo;
    logic [15:0] data;
    logic data_valid;
    logic update;
    logic fmt_err;
    logic bcd_err;
  } mri_state_s;
endpackage

// >>> core/mri_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module mri_sync
  import mri_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire mri_pins_s pins,
  output mri_pins_s clean
);
  mri_sync_s q;
  mri_sync_s d;

  always_comb
  begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a bit moves only once the second and third stages agree
    d.clean = (q.s2 & q.s3) | (q.clean & (q.s2 | q.s3));
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign clean = q.clean;
endmodule

// >>> core/mri_top.sv
// channel-select register input: strobes one field device and returns echo and data
`timescale 1ns/1ns
`include "mri_cfg.svh"
// Behaviour
// RULE1: one channel per cycle, latest request
// RULE2: eight strobed channels share one data path
// RULE3: answer with data plus channel echo
// RULE4: one request register, two readback registers
// RULE5: first readback echo, second field data
// RULE6: BCD mode accepts digits 0000 to 9999
// RULE7: binary mode passes full range to FFFF
// RULE8: address devices by strobes only
// RULE9: strobes active low, idle high
// RULE10: field data stable 180 us after strobe
// RULE11: field data held at least 100 us
// RULE12: field change visible within 20 ms
// RULE13: unsettled field data is never passed
// RULE14: unselected devices release the data lines
// RULE15: polarity switch inverts true-low data
// RULE16: format switch selects BCD or binary
// RULE17: BCD map with BCD switch is erroneous
// RULE18: inputs 32 bits or 2 words, output 16 bits or 1 word
// RULE19: only the requested strobe is ever low
module mri_top
  import mri_pkg::*;
#(
  parameter int STROBE_CYC = `MRI_STROBE_US * `MRI_CLK_MHZ,
  parameter int SETUP_CYC = `MRI_SETUP_US * `MRI_CLK_MHZ,
  parameter int GAP_CYC = `MRI_GAP_US * `MRI_CLK_MHZ
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_wr,
  input wire logic [15:0] req_word,
  input wire logic map_bcd,
  input wire logic fmt_bcd,
  input wire logic pol_low,
  input wire logic [15:0] field_data,
  input wire logic field_value_unsettled,
  output logic [7:0] field_strobe_n,
  output logic [15:0] channel_echo,
  output logic [15:0] selected_channel_data,
  output logic data_update,
  output logic data_valid,
  output logic request_err,
  output logic format_err,
  output logic bcd_digit_err
);
  mri_state_s q;
  mri_state_s d;
  mri_pins_s pins;
  mri_pins_s clean;
  logic [15:0] value;

  function automatic logic [7:0] chan_onehot(input logic [2:0] ch);
    chan_onehot = 8'(1) << ch; // see RULE2
  endfunction

  function automatic logic bad_bcd(input logic [15:0] v);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < `MRI_DATA_W / `MRI_DIGIT_W; i++)
    begin
      if (v[i * `MRI_DIGIT_W +: `MRI_DIGIT_W] > `MRI_DIGIT_MAX)
        bad = 1'b1;
    end
    bad_bcd = bad;
  endfunction

  // switches and field lines are asynchronous to core_clk
  assign pins = '{fmt_bcd: fmt_bcd, pol_low: pol_low,
                  unsettled: field_value_unsettled, data: field_data};

  mri_sync u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pins(pins),
    .clean(clean)
  );

  // data arrives true-low when the polarity switch says so
  assign value = clean.pol_low ? ~clean.data : clean.data; // see RULE15

  always_comb
  begin
    d = q;
    d.update = 1'b0;
    d.fmt_err = map_bcd & clean.fmt_bcd; // see RULE17
    // a request outside the eight channels is refused and flagged
    if (req_wr)
    begin
      if ((req_word & `MRI_REQ_BAD_MASK) != `MRI_WORD_RST)
        d.req_err = 1'b1;
      else
      begin
        d.req_ch = req_word[`MRI_CH_W-1:0]; // see RULE1
        d.req_valid = 1'b1;
        d.req_err = 1'b0;
      end
    end
    case (q.st)
      MRI_IDLE:
      begin
        // the last request is polled again and again so field changes keep flowing
        if (q.req_valid)
        begin
          d.ch = q.req_ch;
          d.strobe_n = ~chan_onehot(q.req_ch); // see RULE8 see RULE19
          d.cnt = '0;
          d.st = MRI_SETUP;
        end
      end
      MRI_SETUP:
      begin
        d.cnt = q.cnt + 20'(1);
        // sample only after the field's setup time has run out
        if (q.cnt == 20'(SETUP_CYC - 1)) // see RULE10
        begin
          d.st = MRI_HOLD;
          if (!clean.unsettled) // see RULE13
          begin
            d.data = value; // see RULE7 see RULE16
            d.echo = 16'(q.ch); // see RULE3 see RULE5
            d.update = 1'b1;
            d.data_valid = 1'b1;
            d.bcd_err = clean.fmt_bcd & bad_bcd(value); // see RULE6
          end
        end
      end
      MRI_HOLD:
      begin
        d.cnt = q.cnt + 20'(1);
        if (q.cnt == 20'(STROBE_CYC - 1)) // see RULE9
        begin
          d.strobe_n = `MRI_STROBE_IDLE;
          d.cnt = '0;
          d.st = MRI_GAP;
        end
      end
      MRI_GAP:
      begin
        // brief idle lets the old device release the shared lines
        d.cnt = q.cnt + 20'(1);
        if (q.cnt == 20'(GAP_CYC - 1))
          d.st = MRI_IDLE;
      end
      default:
      begin
        d.st = MRI_IDLE;
        d.strobe_n = `MRI_STROBE_IDLE;
        d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= MRI_IDLE;
      q.strobe_n <= `MRI_STROBE_IDLE;
    end
    else
      q <= d;
  end

  assign field_strobe_n = q.strobe_n;
  assign channel_echo = q.echo; // see RULE4
  assign selected_channel_data = q.data; // see RULE4 see RULE18
  assign data_update = q.update;
  assign data_valid = q.data_valid;
  assign request_err = q.req_err;
  assign format_err = q.fmt_err;
  assign bcd_digit_err = q.bcd_err;

  // helper: cycles since the last data update while a request stands and the field is settled
  logic [23:0] since_upd_q;
  localparam int RESP_CYC = `MRI_RESPONSE_MS * 1000 * `MRI_CLK_MHZ;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      since_upd_q <= '0;
    else if (q.update || !q.req_valid || clean.unsettled)
      since_upd_q <= '0;
    else if (since_upd_q != 24'hffffff)
      since_upd_q <= since_upd_q + 24'(1);
  end

  // helper: strobe-low stretch and strobe-high stretch, in cycles
  logic [19:0] low_len_q;
  logic [19:0] high_len_q;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_len_q <= '0;
      high_len_q <= '0;
    end
    else if (&field_strobe_n)
    begin
      low_len_q <= '0;
      // saturate so the long idle after reset cannot wrap into a false gap
      if (high_len_q != '1)
        high_len_q <= high_len_q + 20'(1);
    end
    else
    begin
      low_len_q <= low_len_q + 20'(1);
      high_len_q <= '0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  one_strobe_a: assert property ($onehot0(~field_strobe_n)) // see RULE19
    else $error("more than one strobe active");

  strobe_match_a: assert property ((q.st == MRI_SETUP || q.st == MRI_HOLD) // see RULE8
    |-> field_strobe_n == ~chan_onehot(q.ch))
    else $error("strobe does not match active channel");

  strobe_idle_a: assert property ((q.st == MRI_IDLE || q.st == MRI_GAP) // see RULE9
    |-> field_strobe_n == `MRI_STROBE_IDLE)
    else $error("strobe low outside a strobe phase");

  strobe_width_a: assert property ($fell(&field_strobe_n) // see RULE9
    |-> q.cnt == '0 && q.st == MRI_SETUP)
    else $error("strobe started mid count");

  echo_pair_a: assert property (data_update // see RULE3
    |-> channel_echo == 16'($past(q.ch)) && data_valid)
    else $error("echo does not name the sampled channel");

  unsettled_block_a: assert property (q.st == MRI_SETUP && q.cnt == 20'(SETUP_CYC - 1)
    && clean.unsettled |=> !data_update && $stable(selected_channel_data)) // see RULE13
    else $error("unsettled data passed on");

  polarity_data_a: assert property (q.st == MRI_SETUP && q.cnt == 20'(SETUP_CYC - 1)
    && !clean.unsettled |=> selected_channel_data == // see RULE15
    ($past(clean.pol_low) ? ~$past(clean.data) : $past(clean.data)))
    else $error("captured data has wrong polarity");

  format_combo_a: assert property (##1 format_err == $past(map_bcd & clean.fmt_bcd)) // see RULE17
    else $error("format error flag wrong");

  request_take_a: assert property (req_wr && (req_word & `MRI_REQ_BAD_MASK) == '0
    |=> q.req_ch == $past(req_word[2:0]) && !request_err) // see RULE1
    else $error("request word not taken");

  response_bound_a: assert property (since_upd_q < 24'(RESP_CYC)) // see RULE12
    else $error("field data not refreshed in time");

  // scan sequencing
  idle_start_a: assert property (q.st == MRI_IDLE && q.req_valid // see RULE1
    |=> q.st == MRI_SETUP && q.ch == $past(q.req_ch))
    else $error("scan did not start on the latest request");

  scan_channel_a: assert property (q.st != MRI_IDLE |=> q.ch == $past(q.ch)) // see RULE2
    else $error("channel changed inside a scan");

  no_request_quiet_a: assert property (!q.req_valid |-> &field_strobe_n) // see RULE9
    else $error("strobe driven before any request");

  state_onehot_a: assert property ($onehot(q.st)) // see RULE19
    else $error("scan state not one-hot");

  setup_to_hold_a: assert property (q.st == MRI_SETUP // see RULE10
    && q.cnt == 20'(SETUP_CYC - 1) |=> q.st == MRI_HOLD)
    else $error("setup phase length wrong");

  gap_to_idle_a: assert property (q.st == MRI_GAP // see RULE8
    && q.cnt == 20'(GAP_CYC - 1) |=> q.st == MRI_IDLE)
    else $error("gap phase length wrong");

  // strobe timing on the field side
  strobe_low_len_a: assert property (!(&field_strobe_n) // see RULE9
    |-> low_len_q < 20'(STROBE_CYC))
    else $error("strobe held low too long");

  strobe_rise_a: assert property ($rose(&field_strobe_n) // see RULE9
    |-> low_len_q == 20'(STROBE_CYC))
    else $error("strobe width wrong");

  strobe_gap_a: assert property ($fell(&field_strobe_n) && data_valid // see RULE14
    |-> high_len_q == 20'(GAP_CYC + 1))
    else $error("gap between strobes wrong");

  // capture and flags
  capture_time_a: assert property (data_update // see RULE10
    |-> q.st == MRI_HOLD && q.cnt == 20'(SETUP_CYC))
    else $error("capture outside the sample point");

  update_pulse_a: assert property (data_update |=> !data_update) // see RULE1
    else $error("more than one update per scan");

  data_change_a: assert property ($changed(selected_channel_data) |-> data_update) // see RULE13
    else $error("data changed without an update");

  valid_sticky_a: assert property (data_valid |=> data_valid) // see RULE5
    else $error("data valid dropped");

  echo_range_a: assert property (channel_echo < 16'(`MRI_NCH)) // see RULE2
    else $error("echo names no channel");

  bcd_flag_a: assert property (data_update // see RULE6
    |-> bcd_digit_err == ($past(clean.fmt_bcd) & bad_bcd($past(value))))
    else $error("digit error flag wrong");

  binary_pass_a: assert property (data_update && !$past(clean.fmt_bcd) // see RULE7
    |-> !bcd_digit_err)
    else $error("binary capture flagged as bad digits");

  // request register and format flag
  req_refuse_a: assert property (req_wr // see RULE1
    && (req_word & `MRI_REQ_BAD_MASK) != '0 |=> request_err && $stable(q.req_ch))
    else $error("bad request word not refused");

  fmt_ok_a: assert property (!$past(map_bcd) |-> !format_err) // see RULE17
    else $error("format error without a decimal map");

  update_cov: cover property (data_update);
  scan_gap_cov: cover property ($fell(&field_strobe_n) && data_valid);
  blocked_cov: cover property (q.st == MRI_SETUP && clean.unsettled
    && q.cnt == 20'(SETUP_CYC - 1));
  combo_err_cov: cover property (format_err);
  retarget_cov: cover property (req_wr && q.st == MRI_HOLD);
endmodule

// >>> sim/mri_field_model.sv
// field device model: strobe-selected devices on shared data lines
`timescale 1ns/1ns
module mri_field_model #(
  parameter int DLY = 2
)
(
  input wire logic core_clk,
  input wire logic [7:0] strobe_n,
  input wire logic [15:0] vals [8],
  output logic [15:0] data
);
  int cnt = 0;
  logic [15:0] sel;
  initial data = 16'h0000;
  always_comb
  begin
    sel = 16'h0000;
    for (int i = 0; i < 8; i++)
      if (!strobe_n[i])
        sel = vals[i];
  end
  // released lines toggle so stale data never passes for a sample
  always @(posedge core_clk)
  begin
    cnt <= (&strobe_n) ? 0 : cnt + 1;
    if (!(&strobe_n) && cnt >= DLY)
      data <= sel;
    else
      data <= ~data;
  end
endmodule

// >>> sim/mri_top_test.sv
// self-checking bench for the multiplexed register input block
`timescale 1ns/1ns
module mri_top_test;
  import mri_pkg::*;
  typedef struct packed {
    logic [15:0] echo;
    logic [15:0] data;
    logic bcd_err;
  } mri_note_s;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_wr = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic map_bcd = 1'b0;
  logic fmt_bcd = 1'b0;
  logic pol_low = 1'b0;
  logic unsettled = 1'b0;
  logic [15:0] vals [8];
  logic [15:0] fdata;
  logic [7:0] strobe_n;
  logic [15:0] echo;
  logic [15:0] data;
  logic upd;
  logic valid;
  logic rq_err;
  logic f_err;
  logic b_err;
  mri_note_s notes[$];
  int mismatches = 0;
  int samples_checked = 0;
  int updates = 0;
  int held;
  always #5 core_clk = ~core_clk;
  mri_top #(.STROBE_CYC(40), .SETUP_CYC(16), .GAP_CYC(4)) i_dut (.core_clk(core_clk),
    .arst_n(arst_n), .req_wr(req_wr), .req_word(req_word), .map_bcd(map_bcd),
    .fmt_bcd(fmt_bcd), .pol_low(pol_low), .field_data(fdata),
    .field_value_unsettled(unsettled), .field_strobe_n(strobe_n), .channel_echo(echo),
    .selected_channel_data(data), .data_update(upd), .data_valid(valid),
    .request_err(rq_err), .format_err(f_err), .bcd_digit_err(b_err));
  mri_field_model #(.DLY(2)) i_field (.core_clk(core_clk), .strobe_n(strobe_n),
    .vals(vals), .data(fdata));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // outputs are registered, so the pre-edge values form one consistent sample
  always @(posedge core_clk)
  begin
    if (upd === 1'b1)
    begin
      updates++;
      if (notes.size() > 0)
      begin
        chk("echo", echo, notes[0].echo);
        chk("data", data, notes[0].data);
        chk("bcd_err", {15'h0, b_err}, {15'h0, notes[0].bcd_err});
        chk("valid", {15'h0, valid}, 16'h0001);
        chk("strobe", {8'h0, strobe_n}, {8'h0, ~(8'h01 << notes[0].echo[2:0])});
        void'(notes.pop_front());
      end
    end
  end
  task automatic wait_upd(input int n);
    int t;
    int start;
    start = updates;
    t = 0;
    while (updates < start + n && t < 400)
    begin
      @(negedge core_clk);
      t++;
    end
    if (t >= 400)
    begin
      mismatches++;
      $display("[FAIL] update wait expected pulse seen none");
      tally_and_finish();
    end
  endtask
  task automatic request(input logic [15:0] w);
    req_word = w;
    req_wr = 1'b1;
    @(negedge core_clk);
    req_wr = 1'b0;
  endtask
  // the first pulse may still belong to a scan begun before the request
  task automatic poll(input logic [2:0] ch, input logic [15:0] w);
    mri_note_s n;
    request(w);
    wait_upd(1);
    n.echo = {13'h0, ch};
    n.data = pol_low ? ~vals[ch] : vals[ch];
    n.bcd_err = fmt_bcd & ((n.data[3:0] > 9) | (n.data[7:4] > 9) | (n.data[11:8] > 9)
      | (n.data[15:12] > 9));
    notes.push_back(n);
    wait_upd(1);
  endtask
  initial
  begin
    void'($urandom(27));
    foreach (vals[i])
      vals[i] = $urandom();
    vals[0] = 16'hffff;
    vals[7] = 16'h9999;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      pol_low = $urandom();
      fmt_bcd = $urandom();
      poll(3'(i), 16'(i));
    end
    $display("channel sweep done");
    request(16'h000d);
    repeat (3) @(negedge core_clk);
    chk("request_err", {15'h0, rq_err}, 16'h0001);
    poll(3'h7, 16'h0007);
    chk("request_err", {15'h0, rq_err}, 16'h0000);
    $display("bad request done");
    unsettled = 1'b1;
    repeat (6) @(negedge core_clk);
    held = updates;
    repeat (140) @(negedge core_clk);
    chk("blocked", 16'(updates - held), 16'h0000);
    unsettled = 1'b0;
    poll(3'h7, 16'h0007);
    $display("unsettled done");
    map_bcd = 1'b1;
    fmt_bcd = 1'b1;
    repeat (6) @(negedge core_clk);
    chk("format_err", {15'h0, f_err}, 16'h0001);
    fmt_bcd = 1'b0;
    repeat (6) @(negedge core_clk);
    chk("format_err", {15'h0, f_err}, 16'h0000);
    $display("format done");
    tally_and_finish();
  end
endmodule
